// file: hw/urx_cfg.svh
// register map, field positions, reset values and counts of the rx endpoint block
`ifndef URX_CFG_SVH
`define URX_CFG_SVH
// ==========================================================
// register offsets (byte addresses)
`define URX_OFS_CSR 8'h00
`define URX_OFS_CFG 8'h04
`define URX_OFS_DATA 8'h08
`define URX_OFS_PAYLOAD 8'h0C
// ==========================================================
// endpoint control/status field positions
`define URX_BIT_OVR_ERR 18
`define URX_BIT_NO_SPACE 17
`define URX_BIT_PKT_WAIT 16
`define URX_FACTOR_HI 15
`define URX_FACTOR_LO 11
`define URX_LIMIT_HI 10
`define URX_LIMIT_LO 0
// configuration field positions
`define URX_BIT_HOST 0
`define URX_XFER_HI 2
`define URX_XFER_LO 1
`define URX_BIT_HS 3
`define URX_TXLIM_HI 14
`define URX_TXLIM_LO 4
// ==========================================================
// reset values and counts
`define URX_RST_FACTOR 5'h00
`define URX_RST_LIMIT 11'h000
`define URX_RST_TXLIM 11'h000
`define URX_NODATA_TRIES 2'h3
`define URX_HS_MAX_TXN 6'h03
`define URX_RESP_OKAY 2'h0
`define URX_RESP_SLVERR 2'h2
`endif

// file: hw/urx_pkg.sv
// shared types of the rx endpoint block
`include "urx_cfg.svh"
package urx_pkg;
  // transfer type of the endpoint, in register encoding order
  typedef enum logic [1:0] {URX_CTRL, URX_ISO, URX_BULK, URX_INTR} urx_xfer_t;

  // one usb transaction issued by the splitter
  typedef struct packed {
    logic [10:0] len;
    logic [5:0] idx;
    logic last;
  } urx_txn_t;

  typedef enum {URX_SPL_IDLE, URX_SPL_SEND} urx_spl_fsm_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic overrun;
    logic nodata_err;
    logic pkt_wait;
    logic [4:0] factor;
    logic [10:0] rx_limit;
    logic host;
    urx_xfer_t xfer;
    logic hs;
    logic [10:0] tx_limit;
    logic [1:0] miss_cnt;
    logic pkt_ev;
    logic err_ev;
  } urx_state_t;
endpackage

// file: hw/urx_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module urx_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic full_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } urx_fifo_state_t;

  urx_fifo_state_t st_ff, nxt_st;
  logic push, pop;

  assign full_o = (st_ff.cnt == CW'(DEPTH));
  assign in_ready_o = !full_o;
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o = st_ff.mem[st_ff.rd];
  assign count_o = st_ff.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer wrap written out so that non-power-of-two depths work
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data_i;
      nxt_st.wr = bump(st_ff.wr);
    end
    if (pop) begin
      nxt_st.rd = bump(st_ff.rd);
    end
    if (push && !pop) begin
      nxt_st.cnt = CW'(st_ff.cnt + 1'b1);
    end else if (pop && !push) begin
      nxt_st.cnt = CW'(st_ff.cnt - 1'b1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// file: hw/urx_split.sv
// splits one transmit start into the usb transactions the endpoint allows
`timescale 1ns/1ps
`default_nettype none
module urx_split
  import urx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire urx_xfer_t xfer_i,
  input wire logic hs_i,
  input wire logic [4:0] factor_i,
  input wire logic [10:0] tx_limit_i,
  output logic busy_o,
  output logic txn_valid_o,
  input wire logic txn_ready_i,
  output urx_txn_t txn_o
);
  typedef struct packed {
    urx_spl_fsm_t fsm;
    logic [5:0] total;
    logic [5:0] idx;
    logic [10:0] len;
  } urx_spl_state_t;

  urx_spl_state_t st_ff, nxt_st;

  // number of transactions one start produces
  function automatic logic [5:0] txn_count(input urx_xfer_t x, input logic hs,
                                           input logic [4:0] f);
    logic [5:0] fx;
    fx = {1'b0, f};
    txn_count = 6'h01;
    if (x == URX_BULK) begin
      txn_count = 6'(fx + 6'h01);
    end else if (hs && (x == URX_ISO || x == URX_INTR)) begin
      // a factor outside 1..3 is clamped rather than trusted
      txn_count = (fx > `URX_HS_MAX_TXN) ? `URX_HS_MAX_TXN :
                  (fx == 6'h00) ? 6'h01 : fx;
    end
  endfunction

  assign busy_o = (st_ff.fsm == URX_SPL_SEND);
  assign txn_valid_o = busy_o;
  assign txn_o = '{len: st_ff.len, idx: st_ff.idx,
                   last: (6'(st_ff.idx + 6'h01) == st_ff.total)};

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.fsm)
      URX_SPL_IDLE: begin
        if (start_i) begin
          nxt_st.fsm = URX_SPL_SEND;
          nxt_st.total = txn_count(xfer_i, hs_i, factor_i);
          nxt_st.idx = 6'h00;
          nxt_st.len = tx_limit_i;
        end
      end
      URX_SPL_SEND: begin
        if (txn_ready_i) begin
          nxt_st.idx = 6'(st_ff.idx + 6'h01);
          if (txn_o.last) begin
            nxt_st.fsm = URX_SPL_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '{fsm: URX_SPL_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// file: hw/urx_ctrl.sv
// rx endpoint control/status block with axi4-lite register slave
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module urx_ctrl
  import urx_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // axi4-lite slave
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // receive packets from the usb packet engine
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic [31:0] rx_data_i,
  // host-mode receive attempts
  input wire logic rx_try_i,
  input wire logic rx_try_nodata_i,
  // transaction splitting toward the packet engine
  input wire logic tx_start_i,
  output logic tx_busy_o,
  output logic txn_valid_o,
  input wire logic txn_ready_i,
  output urx_txn_t txn_o,
  // events for the controller's interrupt collector
  output logic pkt_event_o,
  output logic err_event_o
);
  urx_state_t st_ff, nxt_st;
  logic fifo_full, fifo_out_valid, fifo_pop, rx_take;
  logic [31:0] fifo_out_data;
  logic [$clog2(DEPTH+1)-1:0] fifo_count;
  logic [16:0] payload;
  logic [31:0] csr_view, wmask;
  logic aw_hs, w_hs, ar_hs, wr_commit;
  logic [7:0] ar_ofs;

  // ==========================================================
  // address decode
  function automatic logic map_hit(input logic [7:0] a);
    map_hit = (a == `URX_OFS_CSR) || (a == `URX_OFS_CFG) ||
              (a == `URX_OFS_DATA) || (a == `URX_OFS_PAYLOAD);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ==========================================================
  // receive queue and splitter
  urx_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i(rx_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data),
    .full_o(fifo_full),
    .count_o(fifo_count)
  );

  urx_split u_split (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(tx_start_i),
    .xfer_i(st_ff.xfer),
    .hs_i(st_ff.hs),
    .factor_i(st_ff.factor),
    .tx_limit_i(st_ff.tx_limit),
    .busy_o(tx_busy_o),
    .txn_valid_o(txn_valid_o),
    .txn_ready_i(txn_ready_i),
    .txn_o(txn_o)
  );

  // ==========================================================
  // status view and bus handshakes
  assign payload = 17'(st_ff.tx_limit) * 17'(6'(st_ff.factor) + 6'h01);
  assign rx_take = rx_valid_i && rx_ready_o;

  always_comb begin
    csr_view = '0;
    // the shared position shows overrun in device mode except bulk, no-data error in host mode except iso
    if (st_ff.host) begin
      csr_view[`URX_BIT_OVR_ERR] = st_ff.nodata_err && (st_ff.xfer != URX_ISO);
    end else begin
      csr_view[`URX_BIT_OVR_ERR] = st_ff.overrun && (st_ff.xfer != URX_BULK);
    end
    csr_view[`URX_BIT_NO_SPACE] = fifo_full;
    csr_view[`URX_BIT_PKT_WAIT] = st_ff.pkt_wait;
    csr_view[`URX_FACTOR_HI:`URX_FACTOR_LO] = st_ff.factor;
    csr_view[`URX_LIMIT_HI:`URX_LIMIT_LO] = st_ff.rx_limit;
  end

  assign s_axi_awready_o = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready_o = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready_o = !st_ff.rvalid;
  assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_commit = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  assign ar_ofs = 8'(s_axi_araddr_i);
  // a data read pops one word; an empty queue reads zero and pops nothing
  assign fifo_pop = ar_hs && (ar_ofs == `URX_OFS_DATA);
  assign wmask = lane_mask(st_ff.wstrb);
  assign s_axi_bvalid_o = st_ff.bvalid;
  assign s_axi_bresp_o = st_ff.bresp;
  assign s_axi_rvalid_o = st_ff.rvalid;
  assign s_axi_rdata_o = st_ff.rdata;
  assign s_axi_rresp_o = st_ff.rresp;
  assign pkt_event_o = st_ff.pkt_ev;
  assign err_event_o = st_ff.err_ev;

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pkt_ev = 1'b0;
    nxt_st.err_ev = 1'b0;
    if (aw_hs) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = 8'(s_axi_awaddr_i);
    end
    if (w_hs) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata_i;
      nxt_st.wstrb = s_axi_wstrb_i;
    end
    if (st_ff.bvalid && s_axi_bready_i) begin
      nxt_st.bvalid = 1'b0;
    end
    // software writes: clears first so that hardware sets below win
    if (wr_commit) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = map_hit(st_ff.awaddr) ? `URX_RESP_OKAY : `URX_RESP_SLVERR;
      if (st_ff.awaddr == `URX_OFS_CSR) begin
        // only a zero clears a flag, a one is ignored
        if (wmask[`URX_BIT_OVR_ERR] && !st_ff.wdata[`URX_BIT_OVR_ERR]) begin
          nxt_st.overrun = 1'b0;
          nxt_st.nodata_err = 1'b0;
        end
        if (wmask[`URX_BIT_PKT_WAIT] && !st_ff.wdata[`URX_BIT_PKT_WAIT]) begin
          nxt_st.pkt_wait = 1'b0;
        end
        nxt_st.factor = (st_ff.factor & ~wmask[`URX_FACTOR_HI:`URX_FACTOR_LO]) |
                        (st_ff.wdata[`URX_FACTOR_HI:`URX_FACTOR_LO] &
                         wmask[`URX_FACTOR_HI:`URX_FACTOR_LO]);
        nxt_st.rx_limit = (st_ff.rx_limit & ~wmask[`URX_LIMIT_HI:`URX_LIMIT_LO]) |
                          (st_ff.wdata[`URX_LIMIT_HI:`URX_LIMIT_LO] &
                           wmask[`URX_LIMIT_HI:`URX_LIMIT_LO]);
      end else if (st_ff.awaddr == `URX_OFS_CFG) begin
        if (st_ff.wstrb[0]) begin
          nxt_st.host = st_ff.wdata[`URX_BIT_HOST];
          nxt_st.xfer = urx_xfer_t'(st_ff.wdata[`URX_XFER_HI:`URX_XFER_LO]);
          nxt_st.hs = st_ff.wdata[`URX_BIT_HS];
        end
        nxt_st.tx_limit = (st_ff.tx_limit & ~wmask[`URX_TXLIM_HI:`URX_TXLIM_LO]) |
                          (st_ff.wdata[`URX_TXLIM_HI:`URX_TXLIM_LO] &
                           wmask[`URX_TXLIM_HI:`URX_TXLIM_LO]);
      end
    end
    // software reads
    if (st_ff.rvalid && s_axi_rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = map_hit(ar_ofs) ? `URX_RESP_OKAY : `URX_RESP_SLVERR;
      nxt_st.rdata = '0;
      if (ar_ofs == `URX_OFS_CSR) begin
        nxt_st.rdata = csr_view;
      end else if (ar_ofs == `URX_OFS_CFG) begin
        nxt_st.rdata[`URX_BIT_HOST] = st_ff.host;
        nxt_st.rdata[`URX_XFER_HI:`URX_XFER_LO] = st_ff.xfer;
        nxt_st.rdata[`URX_BIT_HS] = st_ff.hs;
        nxt_st.rdata[`URX_TXLIM_HI:`URX_TXLIM_LO] = st_ff.tx_limit;
      end else if (ar_ofs == `URX_OFS_DATA) begin
        nxt_st.rdata = fifo_out_valid ? fifo_out_data : '0;
      end else if (ar_ofs == `URX_OFS_PAYLOAD) begin
        nxt_st.rdata = 32'(payload);
      end
    end
    // hardware events
    if (rx_take) begin
      nxt_st.pkt_wait = 1'b1;
      nxt_st.pkt_ev = 1'b1;
    end
    // a device-mode iso packet that meets a full queue is held off, and the overrun flag remembers it
    if (!st_ff.host && st_ff.xfer == URX_ISO && rx_valid_i && !rx_ready_o) begin
      nxt_st.overrun = 1'b1;
    end
    if (st_ff.host && rx_try_i) begin
      if (!rx_try_nodata_i) begin
        nxt_st.miss_cnt = 2'h0;
      end else if (st_ff.xfer == URX_BULK || st_ff.xfer == URX_INTR) begin
        if (2'(st_ff.miss_cnt + 2'h1) == `URX_NODATA_TRIES) begin
          nxt_st.miss_cnt = 2'h0;
          nxt_st.nodata_err = 1'b1;
          nxt_st.err_ev = 1'b1;
        end else begin
          nxt_st.miss_cnt = 2'(st_ff.miss_cnt + 2'h1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= '{factor: `URX_RST_FACTOR, rx_limit: `URX_RST_LIMIT,
                 tx_limit: `URX_RST_TXLIM, xfer: URX_CTRL, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_overrun_set: assert property (
    !st_ff.host && st_ff.xfer == URX_ISO && rx_valid_i && !rx_ready_o |=> st_ff.overrun)
    else $error("overrun not set on refused iso packet");
  a_overrun_bulk: assert property (
    !st_ff.host && st_ff.xfer == URX_BULK |-> !csr_view[`URX_BIT_OVR_ERR])
    else $error("overrun visible in bulk mode");
  a_nodata_set: assert property (
    st_ff.host && st_ff.xfer == URX_BULK && rx_try_i && rx_try_nodata_i &&
    st_ff.miss_cnt == 2'h2 |=> st_ff.nodata_err && err_event_o)
    else $error("third missed attempt did not flag");
  a_nodata_iso: assert property (
    st_ff.host && st_ff.xfer == URX_ISO |-> !csr_view[`URX_BIT_OVR_ERR])
    else $error("no-data error visible in iso mode");
  a_no_space: assert property (
    fifo_count == DEPTH |-> csr_view[`URX_BIT_NO_SPACE] && !rx_ready_o)
    else $error("full queue not reported");
  a_pkt_wait: assert property (rx_take |=> st_ff.pkt_wait && pkt_event_o)
    else $error("packet waiting not raised");
  a_pkt_pulse: assert property (!rx_take |=> !pkt_event_o)
    else $error("packet event not a single pulse");
  a_payload_calc: assert property (
    ar_hs && ar_ofs == `URX_OFS_PAYLOAD |=>
    s_axi_rdata_o == 32'(32'($past(st_ff.tx_limit)) * (32'($past(st_ff.factor)) + 32'h1)))
    else $error("payload size wrong");
  a_one_keeps: assert property (
    wr_commit && st_ff.awaddr == `URX_OFS_CSR &&
    st_ff.wdata[`URX_BIT_PKT_WAIT] && st_ff.pkt_wait |=> st_ff.pkt_wait)
    else $error("writing one cleared a flag");
  a_limit_write: assert property (
    wr_commit && st_ff.awaddr == `URX_OFS_CSR &&
    st_ff.wstrb[1:0] == 2'h3 |=> st_ff.rx_limit == $past(st_ff.wdata[10:0]))
    else $error("rx payload limit not stored");
  a_bulk_split: assert property (
    !tx_busy_o && tx_start_i && st_ff.xfer == URX_BULK &&
    st_ff.factor == 5'h01 ##1 txn_ready_i [*2] |-> ##1 !tx_busy_o)
    else $error("bulk split count wrong");

  c_iso_overrun: cover property (!st_ff.host && st_ff.xfer == URX_ISO && fifo_full && rx_valid_i);
  c_host_nodata: cover property (err_event_o);
  c_data_pop: cover property (fifo_pop && fifo_out_valid);
  c_hs_split: cover property (st_ff.hs && txn_valid_o && txn_o.last && txn_o.idx == 6'h02);
endmodule
`default_nettype wire

// file: bench/urx_peer.sv
// model of the usb packet engine on the far side of the rx endpoint
`timescale 1ns/1ps
`default_nettype none
module urx_peer
  import urx_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic push_i,
  input wire logic [31:0] word_i,
  input wire logic slow_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [31:0] rx_data_o,
  input wire logic txn_valid_i,
  output logic txn_ready_o,
  input wire urx_txn_t txn_i,
  output logic [7:0] txn_cnt_o,
  output urx_txn_t txn_last_o
);
  // ==========================================================
  // packet source and transaction sink
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 32'h0000_0000;
      txn_ready_o <= 1'b0;
      txn_cnt_o <= 8'h00;
      txn_last_o <= '0;
    end else begin
      // a word stays offered while the queue is full, as a real engine would
      if (rx_valid_o && rx_ready_i) begin
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
      end else if (push_i && !rx_valid_o) begin
        rx_valid_o <= 1'b1;
        rx_data_o <= word_i;
      end
      // slow mode stalls every other cycle to stretch each transaction
      txn_ready_o <= slow_i ? !txn_ready_o : 1'b1;
      if (txn_valid_i && txn_ready_o) begin
        txn_cnt_o <= txn_cnt_o + 8'h01;
        txn_last_o <= txn_i;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/test_usb_rx_endpoint_status_ctrl.sv
// self-checking bench of the rx endpoint control/status block
`timescale 1ns/1ps
`default_nettype none
`include "urx_cfg.svh"
module test_usb_rx_endpoint_status_ctrl;
  import urx_pkg::*;
  logic sys_clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rx_valid, rx_ready, rx_try, rx_nodata;
  logic tx_start, tx_busy, txn_valid, txn_ready, push, slow, pkt_ev, err_ev;
  logic [7:0] awaddr, araddr, txn_cnt, n0;
  logic [31:0] wdata, rdata, rx_data, word;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  urx_txn_t txn, txn_last;
  int err_total, comparisons, pkt_n, err_n;
  int xf[6] = '{2, 1, 3, 3, 2, 1};
  int hs[6] = '{0, 1, 1, 1, 0, 0};
  int fc[6] = '{3, 2, 3, 7, 1, 5};
  int ne[6] = '{4, 2, 3, 3, 2, 1};

  urx_ctrl #(.ADDR_W(8), .DEPTH(4)) u_urx_ctrl (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .rx_valid_i(rx_valid),
    .rx_ready_o(rx_ready), .rx_data_i(rx_data), .rx_try_i(rx_try),
    .rx_try_nodata_i(rx_nodata), .tx_start_i(tx_start), .tx_busy_o(tx_busy),
    .txn_valid_o(txn_valid), .txn_ready_i(txn_ready), .txn_o(txn),
    .pkt_event_o(pkt_ev), .err_event_o(err_ev));

  urx_peer u_urx_peer (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .push_i(push), .word_i(word), .slow_i(slow),
    .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .txn_valid_i(txn_valid), .txn_ready_o(txn_ready), .txn_i(txn),
    .txn_cnt_o(txn_cnt), .txn_last_o(txn_last));

  always #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (pkt_ev === 1'b1) pkt_n++;
    if (err_ev === 1'b1) err_n++;
  end

  // ==========================================================
  // reporting
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bail(input string nm);
    err_total++;
    $display("mismatch %s expected handshake seen timeout", nm);
    conclude();
  endtask

  // ==========================================================
  // axi4-lite master: sample ready at the falling edge, act after the rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w, ah, wh, done;
    logic [1:0] rs;
    aw = 1'b1;
    w = 1'b1;
    done = 1'b0;
    rs = 2'h0;
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (n = 0; !done && n < 100; n++) begin
      @(negedge sys_clk);
      ah = aw && awready;
      wh = w && wready;
      done = bvalid;
      rs = bresp;
      @(posedge sys_clk);
      if (ah) aw = 1'b0;
      if (ah) awvalid <= 1'b0;
      if (wh) w = 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    if (!done) bail("write");
    bready <= 1'b0;
    chk("bresp", {30'h0, rs}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                        input string nm);
    int n;
    logic ah, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 1'b0;
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; !done && n < 100; n++) begin
      @(negedge sys_clk);
      ah = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ah) arvalid <= 1'b0;
    end
    if (!done) bail("read");
    rready <= 1'b0;
    chk(nm, d, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask

  // ==========================================================
  // packet engine and host attempt stimulus
  task automatic push_word(input logic [31:0] d, input logic wt);
    int n;
    @(posedge sys_clk);
    push <= 1'b1;
    word <= d;
    @(posedge sys_clk);
    push <= 1'b0;
    for (n = 0; wt && n < 50; n++) begin
      @(negedge sys_clk);
      if (!rx_valid) break;
    end
    if (wt && n == 50) bail("rx word");
  endtask

  task automatic try_rx(input logic nd);
    @(posedge sys_clk);
    rx_try <= 1'b1;
    rx_nodata <= nd;
    @(posedge sys_clk);
    rx_try <= 1'b0;
  endtask

  task automatic fill_drain(input logic [31:0] base, input logic [31:0] csr);
    for (int i = 0; i < 4; i++) push_word(base + 32'(i), 1'b1);
    push_word(base + 32'h0000_0004, 1'b0);
    repeat (4) @(posedge sys_clk);
    rd_chk(`URX_OFS_CSR, csr, `URX_RESP_OKAY, "csr full");
    axi_wr(`URX_OFS_CSR, csr | 32'h0005_0000, `URX_RESP_OKAY);
    rd_chk(`URX_OFS_CSR, csr, `URX_RESP_OKAY, "csr write one");
    for (int i = 0; i < 5; i++) rd_chk(`URX_OFS_DATA, base + 32'(i), 2'h0, "word");
    rd_chk(`URX_OFS_DATA, 32'h0000_0000, `URX_RESP_OKAY, "empty pop");
    rd_chk(`URX_OFS_CSR, csr & 32'hFFFD_FFFF, `URX_RESP_OKAY, "csr drained");
    axi_wr(`URX_OFS_CSR, 32'h0000_1840, `URX_RESP_OKAY);
    rd_chk(`URX_OFS_CSR, 32'h0000_1840, `URX_RESP_OKAY, "csr cleared");
  endtask

  task automatic run_split;
    int n;
    @(posedge sys_clk);
    tx_start <= 1'b1;
    @(posedge sys_clk);
    tx_start <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(negedge sys_clk);
      if (!tx_busy) break;
    end
    if (n == 200) bail("split");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rx_try, rx_nodata, tx_start, push, slow} = '0;
    {awaddr, araddr, wdata, word} = '0;
    wstrb = 4'hF;
    {err_total, comparisons, pkt_n, err_n} = '0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd_chk(`URX_OFS_CSR, 32'h0000_0000, `URX_RESP_OKAY, "csr reset");
    rd_chk(`URX_OFS_PAYLOAD, 32'h0000_0000, `URX_RESP_OKAY, "payload reset");
    axi_wr(`URX_OFS_CSR, 32'h0005_FFFF, `URX_RESP_OKAY);
    rd_chk(`URX_OFS_CSR, 32'h0000_FFFF, `URX_RESP_OKAY, "csr fields");
    // only the lowest byte lane may change
    @(posedge sys_clk) wstrb <= 4'h1;
    axi_wr(`URX_OFS_CSR, 32'h0000_0000, `URX_RESP_OKAY);
    @(posedge sys_clk) wstrb <= 4'hF;
    rd_chk(`URX_OFS_CSR, 32'h0000_FF00, `URX_RESP_OKAY, "csr lanes");
    axi_wr(8'h10, 32'hFFFF_FFFF, `URX_RESP_SLVERR);
    rd_chk(8'h10, 32'h0000_0000, `URX_RESP_SLVERR, "unmapped");
    // device iso, transmit limit 8, even receive limit of 64 bytes
    axi_wr(`URX_OFS_CFG, 32'h0000_0082, `URX_RESP_OKAY);
    axi_wr(`URX_OFS_CSR, 32'h0000_1840, `URX_RESP_OKAY);
    rd_chk(`URX_OFS_PAYLOAD, 32'h0000_0020, `URX_RESP_OKAY, "payload");
    fill_drain(32'hA5A5_0000, 32'h0007_1840);
    chk("packet events", 32'(pkt_n), 32'h0000_0005);
    axi_wr(`URX_OFS_CFG, 32'h0000_0084, `URX_RESP_OKAY);
    fill_drain(32'h5A5A_0010, 32'h0003_1840);
    // host bulk: a try with data restarts the miss count
    axi_wr(`URX_OFS_CFG, 32'h0000_0085, `URX_RESP_OKAY);
    for (int i = 0; i < 5; i++) try_rx(i != 2);
    rd_chk(`URX_OFS_CSR, 32'h0000_1840, `URX_RESP_OKAY, "two misses");
    try_rx(1'b1);
    rd_chk(`URX_OFS_CSR, 32'h0004_1840, `URX_RESP_OKAY, "no data error");
    chk("error events", 32'(err_n), 32'h0000_0001);
    // the set error flag must stay hidden in iso, and iso misses must not count
    axi_wr(`URX_OFS_CFG, 32'h0000_0083, `URX_RESP_OKAY);
    rd_chk(`URX_OFS_CSR, 32'h0000_1840, `URX_RESP_OKAY, "host iso");
    axi_wr(`URX_OFS_CSR, 32'h0000_1840, `URX_RESP_OKAY);
    repeat (3) try_rx(1'b1);
    axi_wr(`URX_OFS_CFG, 32'h0000_0085, `URX_RESP_OKAY);
    rd_chk(`URX_OFS_CSR, 32'h0000_1840, `URX_RESP_OKAY, "error clear");
    for (int i = 0; i < 6; i++) begin
      axi_wr(`URX_OFS_CFG, 32'(128 + hs[i] * 8 + xf[i] * 2), `URX_RESP_OKAY);
      axi_wr(`URX_OFS_CSR, 32'(fc[i] * 2048 + 64), `URX_RESP_OKAY);
      rd_chk(`URX_OFS_PAYLOAD, 32'(8 * (fc[i] + 1)), 2'h0, "payload");
      slow <= i[0];
      n0 = txn_cnt;
      run_split();
      chk("txn count", {24'h0, txn_cnt - n0}, 32'(ne[i]));
      chk("txn last", {14'h0, txn_last}, {14'h0, 11'h008, 6'(ne[i] - 1), 1'b1});
    end
    conclude();
  end
endmodule
`default_nettype wire
